// ===== rtl/pbp_brake_prescale.sv
/*
  Brake and clock prescale logic of a four-output PWM unit, with a
  small period counter fed by the prescaled tick.
  Assumes the compare core supplies the raw outputs on pwm_core, and
  that software reaches the registers on the plain 8-bit port.
*/
// Implementation choice: the plain strobed port.
// Overview of operation
// - Master enable zero never brakes
// - Enabled: mode from halt and pin bits
// - Both mode bits zero: permanent software brake
// - Halt mode: brake only while not running
// - Pin mode: pin brakes, clears run, sets flag
// - Pin asserted when level equals polarity bit
// - Brake drives outputs to level bits
// - Level bit zero low, one high
// - Brake release restores pre-brake output state
// - Prescale codes divide by 1,2,4,16
// - Prescaler phase aligned while halted
// - Flag set by hardware, cleared by software
// - Control two resets zero, reserved bits
// - Flag pollable and requests interrupt
// - Period rate is tick over one plus period
// - Run bit stops or runs the counter
module pbp_brake_prescale
  import pbp_pkg::*;
#(
  parameter int unsigned N_OUT = 4,
  parameter int unsigned CNT_W = 10
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic brake_pin,
  input wire logic [N_OUT-1:0] pwm_core,
  input wire logic pwm_int_en,
  output logic [N_OUT-1:0] pwm_out,
  output logic brake_active,
  output logic counter_run,
  output logic prescale_tick,
  output logic period_end,
  output logic brake_irq
);

  // Prescale mask lookup, used by the tick only; the checks test fp_q directly
  function automatic logic [3:0] div_mask(input logic [1:0] code);
    case (pbp_div_t'(code))
      PBP_DIV1: div_mask = MASK_DIV1;
      PBP_DIV2: div_mask = MASK_DIV2;
      PBP_DIV4: div_mask = MASK_DIV4;
      PBP_DIV16: div_mask = MASK_DIV16;
      default: div_mask = MASK_DIV1;
    endcase
  endfunction

  logic run_q, run_d;
  logic [7:0] ctrl1_q;
  logic [1:0] fp_q;
  logic flag_q, flag_d;
  logic [CNT_W-1:0] period_q, cnt_q;
  logic [1:0] pin_sync_q;
  logic brake_q;
  logic [N_OUT-1:0] out_q, saved_q;
  logic [3:0] pre_cnt_q;
  logic per_end_q;
  logic [7:0] rdata_q;

  // Write strobes per register
  wire wr_ctrl0 = reg_wr && (reg_addr == ADDR_CTRL_ZERO);
  wire wr_ctrl1 = reg_wr && (reg_addr == ADDR_CTRL_ONE);
  wire wr_ctrl2 = reg_wr && (reg_addr == ADDR_CTRL_TWO);
  wire wr_plo = reg_wr && (reg_addr == ADDR_PERIOD_LO);
  wire wr_phi = reg_wr && (reg_addr == ADDR_PERIOD_HI);

  // Control one fields
  wire master_en = ctrl1_q[BIT_MASTER_EN];
  wire halt_sel = ctrl1_q[BIT_HALT_SEL];
  wire pin_en = ctrl1_q[BIT_PIN_EN];
  wire pol_sel = ctrl1_q[BIT_POL_SEL];
  wire [N_OUT-1:0] levels = ctrl1_q[LVL_LSB +: N_OUT];

  // Pin level matched against polarity, second sync stage only
  wire pin_asserted = (pin_sync_q[1] == pol_sel);

  // Brake selection; both mode bits set gives no brake
  wire soft_brake = !pin_en && !halt_sel;
  wire halt_brake = !pin_en && halt_sel && !run_q;
  wire pin_trip = master_en && pin_en && !halt_sel && pin_asserted;
  wire brake_d = master_en && (soft_brake || halt_brake || pin_trip);

  // Run bit: pin trip beats a software write, so a brake holds
  always_comb begin
    run_d = run_q;
    if (wr_ctrl0) begin
      run_d = reg_wdata[BIT_RUN];
    end
    if (pin_trip) begin
      run_d = 1'b0;
    end
  end

  // Flag: a hardware set wins over a clearing write
  always_comb begin
    flag_d = flag_q;
    if (wr_ctrl2) begin
      flag_d = reg_wdata[BIT_FLAG];
    end
    if (pin_trip) begin
      flag_d = 1'b1;
    end
  end

  // Registers written by software; reset to zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
      ctrl1_q <= RST_CTRL;
      fp_q <= 2'h0;
      flag_q <= 1'b0;
      period_q <= RST_PERIOD;
    end else begin
      run_q <= run_d;
      flag_q <= flag_d;
      if (wr_ctrl1) ctrl1_q <= reg_wdata;
      if (wr_ctrl2) fp_q <= reg_wdata[FP_LSB +: 2];
      if (wr_plo) period_q[7:0] <= reg_wdata;
      if (wr_phi) period_q[CNT_W-1:8] <= reg_wdata[CNT_W-9:0];
    end
  end

  // Read mux; reserved and unmapped bits read zero
  wire [7:0] rd_ctrl0 = {run_q, 7'h00};
  wire [7:0] rd_ctrl2 = {4'h0, fp_q, 1'b0, flag_q};
  wire [7:0] rd_phi = {{(16-CNT_W){1'b0}}, period_q[CNT_W-1:8]};
  wire [7:0] rd_mux =
    (reg_addr == ADDR_CTRL_ZERO) ? rd_ctrl0 :
    (reg_addr == ADDR_CTRL_ONE) ? ctrl1_q :
    (reg_addr == ADDR_CTRL_TWO) ? rd_ctrl2 :
    (reg_addr == ADDR_PERIOD_LO) ? period_q[7:0] :
    (reg_addr == ADDR_PERIOD_HI) ? rd_phi : 8'h00;

  // Read data stands one cycle, zero otherwise
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Two-stage pin synchroniser
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_sync_q <= 2'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[0], brake_pin};
    end
  end

  // Prescaler held at zero while halted, so the first tick after
  // run rises lands at a fixed phase of the system clock
  wire [3:0] mask = div_mask(fp_q);
  wire pre_tick = run_q && ((pre_cnt_q & mask) == mask);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt_q <= 4'h0;
    end else if (!run_q) begin
      pre_cnt_q <= 4'h0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 4'h1;
    end
  end

  // Period counter: counts down on ticks, reloads after zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      per_end_q <= 1'b0;
    end else begin
      per_end_q <= pre_tick && (cnt_q == '0);
      if (pre_tick) begin
        cnt_q <= (cnt_q == '0) ? period_q : cnt_q - 1'b1;
      end
    end
  end

  // Brake state and saved pre-brake outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      brake_q <= 1'b0;
      saved_q <= '0;
    end else begin
      brake_q <= brake_d;
      if (!brake_q) saved_q <= out_q;
    end
  end

  // Output select per bit: brake level, restore, or core value;
  // one process owns the whole output register, so no split drivers
  wire restore = brake_q && !brake_d;
  wire [N_OUT-1:0] out_d;
  generate
    for (genvar i = 0; i < N_OUT; i++) begin : g_out
      assign out_d[i] = brake_d ? levels[i] :
                        restore ? saved_q[i] : pwm_core[i];
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign pwm_out = out_q;
  assign brake_active = brake_q;
  assign counter_run = run_q;
  assign prescale_tick = pre_tick;
  assign period_end = per_end_q;
  assign brake_irq = flag_q && pwm_int_en;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence pin_trip_s;
    master_en && pin_en && !halt_sel && (pin_sync_q[1] == pol_sel);
  endsequence

  sequence trip_effect_s;
    brake_q && !run_q && flag_q;
  endsequence

  a_master_off: assert property (!master_en |=> !brake_q)
    else $error("brake asserted with master enable clear");

  a_soft_brake: assert property (
    master_en && !pin_en && !halt_sel |=> brake_q)
    else $error("software brake not asserted");

  a_halt_brake: assert property (
    master_en && halt_sel && !pin_en |=> brake_q == !$past(run_q))
    else $error("halt brake does not follow run bit");

  a_bad_combo: assert property (
    master_en && halt_sel && pin_en |=> !brake_q)
    else $error("brake taken for forbidden combination");

  a_pin_trip: assert property (pin_trip_s |=> trip_effect_s)
    else $error("pin brake did not stop run and set flag");

  a_pin_polarity: assert property (
    master_en && pin_en && !halt_sel && $past(brake_pin, 2) == pol_sel
    && $stable(pol_sel) && $stable(ctrl1_q) |=> brake_q)
    else $error("pin level equal to polarity did not brake");

  a_out_levels: assert property (
    brake_q |-> pwm_out == $past(levels))
    else $error("brake outputs differ from level bits");

  a_restore: assert property (
    $fell(brake_q) |-> pwm_out == $past(saved_q))
    else $error("outputs not restored after brake");

  a_flag_hold: assert property (
    flag_q && !(wr_ctrl2 && !reg_wdata[BIT_FLAG]) |=> flag_q)
    else $error("flag cleared without software write");

  a_div16_gap: assert property (
    pre_tick && fp_q == 2'h3 && !wr_ctrl2 ##1 run_q && !wr_ctrl2
    |-> !pre_tick [*8])
    else $error("divide by 16 ticks too often");

  a_div1_every: assert property (run_q && fp_q == 2'h0 |-> pre_tick)
    else $error("divide by 1 missing a tick");

  // The count may still stand in the cycle run falls; cleared after
  a_halted_quiet: assert property (
    !run_q |-> !pre_tick ##1 pre_cnt_q == 4'h0)
    else $error("prescaler moving while halted");

  a_period_reload: assert property (
    pre_tick && cnt_q == '0 |=> period_end && cnt_q == $past(period_q))
    else $error("period counter did not reload on end");

  a_read_ctrl2: assert property (
    reg_rd && reg_addr == ADDR_CTRL_TWO |=> reg_rdata == $past(rd_ctrl2))
    else $error("control two read data wrong");

  // Goes through the flag logic, not just the output gate
  a_irq_req: assert property (
    pin_trip_s ##1 pwm_int_en |-> brake_irq)
    else $error("interrupt request missing");

endmodule

// ===== rtl/pbp_pkg.sv
/*
  Shared constants for the PWM brake and prescale block: register
  offsets, field positions, reset values and prescale codes.
  Assumes an 8-bit register port and a single 40 MHz clock.
*/
package pbp_pkg;
  // Clock rate, for reference by timing constants
  localparam int unsigned CLK_HZ = 40000000;

  // Register offsets on the 8-bit register port
  localparam logic [7:0] ADDR_CTRL_ZERO = 8'hdc;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'hdf;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'hd7;
  localparam logic [7:0] ADDR_PERIOD_LO = 8'hd1;
  localparam logic [7:0] ADDR_PERIOD_HI = 8'hd2;

  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [9:0] RST_PERIOD = 10'h000;

  // Field positions, control zero
  localparam int unsigned BIT_RUN = 7;
  // Field positions, control one
  localparam int unsigned BIT_HALT_SEL = 7;
  localparam int unsigned BIT_POL_SEL = 6;
  localparam int unsigned BIT_PIN_EN = 5;
  localparam int unsigned BIT_MASTER_EN = 4;
  localparam int unsigned LVL_LSB = 0;
  // Field positions, control two
  localparam int unsigned FP_LSB = 2;
  localparam int unsigned BIT_FLAG = 0;

  // Prescale codes
  typedef enum logic [1:0] {
    PBP_DIV1,
    PBP_DIV2,
    PBP_DIV4,
    PBP_DIV16
  } pbp_div_t;

  // Prescale counter masks per code
  localparam logic [3:0] MASK_DIV1 = 4'h0;
  localparam logic [3:0] MASK_DIV2 = 4'h1;
  localparam logic [3:0] MASK_DIV4 = 4'h3;
  localparam logic [3:0] MASK_DIV16 = 4'hf;
endpackage

// ===== sim/pbp_pin_model.sv
/*
  Model of the external brake pin source.
  Assumes the bench sets the polarity to match the register setting.
*/
module pbp_pin_model (
  input wire logic trip,
  input wire logic pol,
  output logic brake_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Trip is a held level, as from an external latch
  // Idle pin sits at the inactive level, never floats
  assign brake_pin = trip ? pol : ~pol;
endmodule

// ===== sim/testbench.sv
/*
  Self-checking bench for the brake and prescale block.
  Assumes the one-cycle register port and a 40 MHz clock.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, nrst, reg_wr, reg_rd, pwm_int_en, trip, pol;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] pwm_core, pwm_out;
  logic brake_pin, brake_active, counter_run, prescale_tick, period_end, brake_irq;
  int miscompares, compares;
  logic [7:0] div_exp [4] = '{8'h01, 8'h02, 8'h04, 8'h10};

  pbp_brake_prescale dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .brake_pin(brake_pin), .pwm_core(pwm_core), .pwm_int_en(pwm_int_en),
    .pwm_out(pwm_out), .brake_active(brake_active), .counter_run(counter_run),
    .prescale_tick(prescale_tick), .period_end(period_end), .brake_irq(brake_irq));
  pbp_pin_model pin (.trip(trip), .pol(pol), .brake_pin(brake_pin));

  // Free-running system clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Step whole cycles, then settle past the edge
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  // Cycles between two pulses; bounded so a dead pulse cannot hang
  task gap(input bit pe, input logic [7:0] e);
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (!(pe ? period_end : prescale_tick) && n < 40);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (!(pe ? period_end : prescale_tick) && n < 40);
    chk(8'(n), e);
  endtask

  task give_verdict;
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles of the run
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end

  initial begin
    nrst = 1'b0;
    {reg_wr, reg_rd, trip, pol} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    pwm_core = 4'h5;
    pwm_int_en = 1'b1;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(8'hd7, 8'h00);
    rd(8'hdf, 8'h00);
    rd(8'hdc, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'hd7, 8'hff);
    rd(8'hd7, 8'h0d);
    wr(8'hd7, 8'h00);
    wr(8'hdf, 8'h0a);
    cyc(2);
    chk(8'(brake_active), 8'h00);
    chk(8'(pwm_out), 8'h05);
    wr(8'hdf, 8'h1a);
    cyc(2);
    chk(8'(brake_active), 8'h01);
    chk(8'(pwm_out), 8'h0a);
    @(posedge ref_clk);
    pwm_core <= 4'hc;
    wr(8'hdf, 8'h0a);
    cyc(1);
    chk(8'(pwm_out), 8'h05);
    cyc(1);
    chk(8'(pwm_out), 8'h0c);
    wr(8'hdf, 8'h93);
    cyc(2);
    chk(8'(brake_active), 8'h01);
    chk(8'(pwm_out), 8'h03);
    wr(8'hdc, 8'h80);
    cyc(2);
    chk(8'(brake_active), 8'h00);
    rd(8'hdc, 8'h80);
    // Every prescale code, measured as the tick spacing
    for (int i = 0; i < 4; i++) begin
      wr(8'hd7, {4'h0, 2'(i), 2'b00});
      gap(1'b0, div_exp[i]);
    end
    wr(8'hd7, 8'h04);
    wr(8'hd1, 8'h03);
    wr(8'hd2, 8'h00);
    gap(1'b1, 8'h08);
    wr(8'hdc, 8'h00);
    repeat (4) begin
      cyc(1);
      chk(8'(prescale_tick), 8'h00);
    end
    // Pin brake under both polarities; polarity and interrupt enable
    // change with the pin mode off, so the pin cannot trip early
    for (int p = 0; p < 2; p++) begin
      wr(8'hdf, {1'b0, p[0], 6'h00});
      pol <= p[0];
      pwm_int_en <= p[0];
      wr(8'hdc, 8'h80);
      wr(8'hdf, {1'b0, p[0], 6'h30});
      cyc(5);
      chk(8'(brake_active), 8'h00);
      trip <= 1'b1; // Held five cycles, long enough to poll
      cyc(5);
      chk({5'h00, brake_active, counter_run, brake_irq}, {7'h02, p[0]});
      chk(8'(pwm_out), 8'h00);
      trip <= 1'b0;
      cyc(5);
      chk(8'(brake_active), 8'h00);
      rd(8'hd7, 8'h05);
      wr(8'hd7, 8'h04);
      rd(8'hd7, 8'h04);
      chk(8'(brake_irq), 8'h00);
    end
    // Forbidden mode pair: no brake even with pin tripped and halted
    pol <= 1'b0;
    trip <= 1'b1;
    wr(8'hdc, 8'h00);
    wr(8'hdf, 8'hb0);
    cyc(5);
    chk(8'(brake_active), 8'h00);
    rd(8'hd7, 8'h04);
    give_verdict();
  end
endmodule
